// ### rtl/sync_io_ctrl.sv
// What this block does
// (R1) Clock mode picks internal master clock or the preferred external source.
// (R2) In automatic mode a missing preferred source falls to the next available one.
// (R3) Scan word clock, both optical, SPDIF; LTC and video only with timecode option.
// (R4) No valid candidate in automatic mode: run from internal clock as master.
// (R5) Report clock state: master on own clock, slave when following a reference.
// (R6) Report the active sync source and its measured sample frequency.
// (R7) Report no lock, lock or sync for word clock, both optical, SPDIF.
// (R8) Word clock output runs at the current sample rate by default.
// (R9) Base-rate option keeps word clock within 32 to 48 kHz.
// (R10) Full bandwidth enables all 28 input and 28 output channels.
// (R11) Second-optical-off bandwidth disables channels 21 to 28 only.
// (R12) Analog-plus-SPDIF bandwidth keeps the 10 analog channels and SPDIF pair.
// (R13) Narrowest bandwidth keeps analog channels one to eight only.
// (R14) SPDIF receive comes from coaxial or second optical input.
// (R15) SPDIF transmit always drives coaxial; also second optical when selected.
// (R16) Measure the SPDIF input sample rate as its own status value.
// (R17) Error indication shows only after errors; count clears on transport start.
// (R18) Passthrough option forwards SPDIF channel status and track markers to host.
// (R19) Configuration writes take effect at once; host avoids changes while running.
// (R20) An input is available for selection only in lock or sync state.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sync_io_ctrl
  import sync_io_pkg::*;
#(
  parameter int GATE_LEN = GATE_CYCLES,
  parameter int ERR_W = 16
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic [5:0] lock_pin, // per-source valid signal
  input wire logic [5:0] sync_pin, // per-source synchronous
  input wire logic [5:0] ref_clk_pin, // per-source recovered word rate
  input wire logic tc_fitted_pin, // timecode option present
  output logic use_internal_clk, // clock generator select
  output logic [2:0] ref_sel, // reference routed to the pll
  output logic wck_out, // word clock output
  output logic [27:0] in_chan_en, // host input channel enables
  output logic [27:0] out_chan_en, // host output channel enables
  input wire logic spdif_coax_rx, // coaxial receive line
  input wire logic opt2_rx, // second optical receive line
  output logic spdif_rx, // to spdif receiver
  input wire logic spdif_tx, // from spdif transmitter
  input wire logic opt2_data_tx, // multichannel data for optical two
  output logic spdif_coax_tx, // coaxial transmit line
  output logic opt2_tx, // second optical transmit line
  input wire logic host_err, // host transfer error pulse
  input wire logic xport_start, // playback or record start pulse
  input wire logic cs_valid, // spdif status byte strobe
  input wire logic [7:0] cs_data, // spdif status and marker byte
  output logic cs_fwd_valid, // forwarded status strobe
  output logic [7:0] cs_fwd_data // forwarded status byte
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [3:0] pick_src(input logic [5:0] av, input logic [2:0] pref);
    logic [3:0] r;
    int s;
    r = 4'h0;
    for (int k = 5; k >= 0; k--) begin
      s = (int'(pref) + k) % 6;
      if (av[s]) begin
        r = {1'b1, 3'(s)};
      end
    end
    return r;
  endfunction : pick_src

  function automatic speed_type speed_of(input logic [15:0] khz);
    if (khz >= QUAD_KHZ) begin
      return SPD_QUAD;
    end else if (khz >= DOUBLE_KHZ) begin
      return SPD_DOUBLE;
    end
    return SPD_SINGLE;
  endfunction : speed_of

  function automatic logic [27:0] bw_mask(input bw_type bw);
    case (bw)
      BW_ALL: return MASK_ALL; // R10
      BW_NO_OPT2: return MASK_NO_OPT2; // R11
      BW_AN_SPDIF: return MASK_AN_SPDIF; // R12
      BW_AN8: return MASK_AN8; // R13
      default: return MASK_ALL;
    endcase
  endfunction : bw_mask

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] lock_s1_q, lock_s2_q, sync_s1_q, sync_s2_q;
  logic [5:0] ref_s1_q, ref_s2_q, ref_s3_q;
  logic tc_s1_q, tc_s2_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_s1_q <= 6'h00;
      lock_s2_q <= 6'h00;
      sync_s1_q <= 6'h00;
      sync_s2_q <= 6'h00;
      tc_s1_q <= 1'b0;
      tc_s2_q <= 1'b0;
    end else begin
      lock_s1_q <= lock_pin;
      lock_s2_q <= lock_s1_q;
      sync_s1_q <= sync_pin;
      sync_s2_q <= sync_s1_q;
      tc_s1_q <= tc_fitted_pin;
      tc_s2_q <= tc_s1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_s1_q <= 6'h00;
      ref_s2_q <= 6'h00;
      ref_s3_q <= 6'h00;
    end else begin
      ref_s1_q <= ref_clk_pin;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  logic [5:0] ref_rise, ref_edge;
  assign ref_rise = ref_s2_q & ~ref_s3_q;
  assign ref_edge = ref_s2_q ^ ref_s3_q;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [11:0] ctrl_q;
  logic [15:0] intdiv_q;
  logic auto_mode;
  logic [2:0] pref_src;
  bw_type bw_sel;
  speed_type int_speed;
  assign auto_mode = ctrl_q[CTRL_AUTO];
  assign pref_src = ctrl_q[CTRL_PREF_LSB +: 3];
  assign bw_sel = bw_type'(ctrl_q[CTRL_BW_LSB +: 2]);
  assign int_speed = speed_type'(ctrl_q[CTRL_SPEED_LSB +: 2]);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      intdiv_q <= INTDIV_RST;
    end else if (reg_wr) begin
      if (reg_addr == A_CTRL) begin
        ctrl_q <= reg_wdata[CTRL_W-1:0]; // R19
      end
      if (reg_addr == A_INTDIV) begin
        intdiv_q <= reg_wdata[15:0]; // R19
      end
    end
  end

  // ----------------------------------------
  // lock report and source selection
  // ----------------------------------------
  lock_type lock_rep_q [6];
  logic [5:0] avail;
  logic [3:0] pick;
  src_type active_src_q;
  clk_state_type clk_state_q;

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 6; i++) begin
      if (rst || !lock_s2_q[i]) begin
        lock_rep_q[i] <= LK_NONE; // R7
      end else if (sync_s2_q[i]) begin
        lock_rep_q[i] <= LK_SYNC; // R7
      end else begin
        lock_rep_q[i] <= LK_LOCK; // R7
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      avail[i] = (lock_rep_q[i] != LK_NONE); // R20
    end
    if (!tc_s2_q) begin
      avail[SRC_LTC] = 1'b0; // R3
      avail[SRC_VIDEO] = 1'b0; // R3
    end
  end

  assign pick = pick_src(avail, pref_src); // R2 R3

  always_ff @(posedge core_clk) begin
    if (rst) begin
      active_src_q <= SRC_WCK;
      clk_state_q <= CS_MASTER;
    end else if (auto_mode && pick[3]) begin
      active_src_q <= src_type'(pick[2:0]); // R1 R2
      clk_state_q <= CS_SLAVE; // R5
    end else begin
      clk_state_q <= CS_MASTER; // R1 R4 R5
    end
  end

  assign use_internal_clk = (clk_state_q == CS_MASTER); // R5
  assign ref_sel = active_src_q; // R6

  // ----------------------------------------
  // frequency measurement
  // ----------------------------------------
  logic [31:0] gate_cnt_q;
  logic [15:0] ref_acc_q, spdif_acc_q, ref_khz_q, spdif_khz_q;
  logic gate_end;
  assign gate_end = (gate_cnt_q == 32'(GATE_LEN - 1));

  always_ff @(posedge core_clk) begin
    if (rst || gate_end) begin
      gate_cnt_q <= 32'h0000_0000;
    end else begin
      gate_cnt_q <= gate_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_acc_q <= 16'h0000;
      spdif_acc_q <= 16'h0000;
      ref_khz_q <= 16'h0000;
      spdif_khz_q <= 16'h0000;
    end else if (gate_end) begin
      ref_khz_q <= ref_acc_q; // R6
      spdif_khz_q <= spdif_acc_q; // R16
      ref_acc_q <= {15'h0000, ref_rise[active_src_q]};
      spdif_acc_q <= {15'h0000, ref_rise[SRC_SPDIF]};
    end else begin
      ref_acc_q <= ref_acc_q + {15'h0000, ref_rise[active_src_q]};
      spdif_acc_q <= spdif_acc_q + {15'h0000, ref_rise[SRC_SPDIF]};
    end
  end

  // ----------------------------------------
  // word clock output
  // ----------------------------------------
  logic [15:0] int_cnt_q;
  logic int_tick, wck_tick;
  logic [1:0] wck_div_q, wck_div_top;
  logic wck_q;
  speed_type cur_speed;

  assign int_tick = (int_cnt_q == 16'h0000);
  always_ff @(posedge core_clk) begin
    if (rst || int_tick) begin
      int_cnt_q <= intdiv_q;
    end else begin
      int_cnt_q <= int_cnt_q - 16'h0001;
    end
  end

  assign cur_speed = use_internal_clk ? int_speed : speed_of(ref_khz_q);
  assign wck_tick = use_internal_clk ? int_tick : ref_edge[active_src_q]; // R8
  always_comb begin
    wck_div_top = 2'h0; // R8
    if (ctrl_q[CTRL_WCK_SINGLE]) begin
      case (cur_speed)
        SPD_DOUBLE: wck_div_top = 2'h1; // R9
        SPD_QUAD: wck_div_top = 2'h3; // R9
        default: wck_div_top = 2'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wck_div_q <= 2'h0;
      wck_q <= 1'b0;
    end else if (wck_tick) begin
      if (wck_div_q >= wck_div_top) begin
        wck_div_q <= 2'h0;
        wck_q <= ~wck_q; // R8 R9
      end else begin
        wck_div_q <= wck_div_q + 2'h1;
      end
    end
  end
  assign wck_out = wck_q;

  // ----------------------------------------
  // bandwidth and spdif routing
  // ----------------------------------------
  logic [27:0] chan_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chan_q <= MASK_ALL;
    end else begin
      chan_q <= bw_mask(bw_sel); // R10 R11 R12 R13
    end
  end
  assign in_chan_en = chan_q;
  assign out_chan_en = chan_q;

  assign spdif_rx = ctrl_q[CTRL_SPDIF_IN_OPT] ? opt2_rx : spdif_coax_rx; // R14
  assign spdif_coax_tx = spdif_tx; // R15
  assign opt2_tx = ctrl_q[CTRL_SPDIF_OUT_OPT] ? spdif_tx : opt2_data_tx; // R15

  // ----------------------------------------
  // host errors and status passthrough
  // ----------------------------------------
  logic [ERR_W-1:0] err_cnt_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_cnt_q <= '0;
    end else if (xport_start) begin
      err_cnt_q <= {{(ERR_W-1){1'b0}}, host_err}; // R17
    end else if (host_err && !(&err_cnt_q)) begin
      err_cnt_q <= err_cnt_q + 1'b1; // R17
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_fwd_valid <= 1'b0;
      cs_fwd_data <= 8'h00;
    end else begin
      cs_fwd_valid <= cs_valid && ctrl_q[CTRL_PASSTHRU]; // R18
      if (cs_valid && ctrl_q[CTRL_PASSTHRU]) begin
        cs_fwd_data <= cs_data; // R18
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [31:0] rd_d, status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_SLAVE] = clk_state_q; // R5
    status_word[ST_SRC_LSB +: 3] = active_src_q; // R6
    for (int i = 0; i < 4; i++) begin
      status_word[ST_LOCK_LSB + 2*i +: 2] = lock_rep_q[i]; // R7
    end
    status_word[ST_TC_FITTED] = tc_s2_q;
    case (reg_addr)
      A_CTRL: rd_d = {20'h00000, ctrl_q};
      A_INTDIV: rd_d = {16'h0000, intdiv_q};
      A_STATUS: rd_d = status_word;
      A_REF_FREQ: rd_d = {16'h0000, ref_khz_q}; // R6
      A_SPDIF_FREQ: rd_d = {16'h0000, spdif_khz_q}; // R16
      A_ERRORS: rd_d = 32'({(err_cnt_q != '0), 16'(err_cnt_q)}); // R17
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rd_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_MASTER_MODE: assert property (@(posedge core_clk) disable iff (rst) // R1
    !auto_mode |=> use_internal_clk)
    else $error("master mode not on internal clock");

  AST_PREF_WINS: assert property (@(posedge core_clk) disable iff (rst) // R2
    auto_mode && avail[pref_src] && pref_src <= 3'h5
      |=> !use_internal_clk && active_src_q == $past(pref_src))
    else $error("preferred source not taken");

  AST_NO_TC: assert property (@(posedge core_clk) disable iff (rst) // R3
    !tc_s2_q && auto_mode |=> use_internal_clk || active_src_q < SRC_LTC)
    else $error("timecode source used without option");

  AST_FALLBACK: assert property (@(posedge core_clk) disable iff (rst) // R4
    avail == 6'h00 |=> clk_state_q == CS_MASTER)
    else $error("no fallback to master");

  AST_SLAVE_AVAIL: assert property (@(posedge core_clk) disable iff (rst) // R20
    !use_internal_clk |-> ((($past(avail) >> active_src_q) & 6'h01) != 6'h00))
    else $error("slave on unavailable source");

  AST_LOCK_SYNC: assert property (@(posedge core_clk) disable iff (rst) // R7
    lock_s2_q[0] && sync_s2_q[0] |=> lock_rep_q[0] == LK_SYNC)
    else $error("sync state not reported");

  AST_BW_ANALOG8: assert property (@(posedge core_clk) disable iff (rst) // R13
    bw_sel == BW_AN8 |=> in_chan_en == MASK_AN8 && out_chan_en == MASK_AN8)
    else $error("narrow bandwidth mask wrong");

  AST_BW_NO_OPT2: assert property (@(posedge core_clk) disable iff (rst) // R11
    bw_sel == BW_NO_OPT2 |=> in_chan_en[27:20] == 8'h00 && &in_chan_en[19:0])
    else $error("second optical channels not dropped");

  AST_SPDIF_OUT: assert property (@(posedge core_clk) disable iff (rst) // R15
    ctrl_q[CTRL_SPDIF_OUT_OPT] |-> opt2_tx == spdif_tx && spdif_coax_tx == spdif_tx)
    else $error("spdif transmit routing wrong");

  AST_ERR_CLEAR: assert property (@(posedge core_clk) disable iff (rst) // R17
    xport_start && !host_err |=> err_cnt_q == '0 ##1 (err_cnt_q == '0 || $past(host_err)))
    else $error("error count not cleared at start");

  AST_PASSTHRU_OFF: assert property (@(posedge core_clk) disable iff (rst) // R18
    !ctrl_q[CTRL_PASSTHRU] |=> !cs_fwd_valid)
    else $error("status forwarded while disabled");

  AST_CTRL_WRITE: assert property (@(posedge core_clk) disable iff (rst) // R19
    reg_wr && reg_addr == A_CTRL |=> ctrl_q == $past(reg_wdata[CTRL_W-1:0]))
    else $error("control write not applied at once");

endmodule : sync_io_ctrl
`default_nettype wire

// ### shared/sync_io_pkg.sv
package sync_io_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int GATE_MS = 1;
  localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_MS;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INTDIV = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_REF_FREQ = 8'h0C;
  localparam logic [7:0] A_SPDIF_FREQ = 8'h10;
  localparam logic [7:0] A_ERRORS = 8'h14;
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_PREF_LSB = 1;
  localparam int CTRL_WCK_SINGLE = 4;
  localparam int CTRL_BW_LSB = 5;
  localparam int CTRL_SPDIF_IN_OPT = 7;
  localparam int CTRL_SPDIF_OUT_OPT = 8;
  localparam int CTRL_PASSTHRU = 9;
  localparam int CTRL_SPEED_LSB = 10;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [15:0] INTDIV_RST = 16'h0068;
  localparam int ST_SLAVE = 0;
  localparam int ST_SRC_LSB = 1;
  localparam int ST_LOCK_LSB = 4;
  localparam int ST_TC_FITTED = 12;
  localparam int ERR_VIS_BIT = 16;
  // ----------------------------------------
  // channels and rates
  // ----------------------------------------
  localparam int NUM_CH = 28;
  localparam logic [27:0] MASK_ALL = 28'hFFFFFFF;
  localparam logic [27:0] MASK_NO_OPT2 = 28'h00FFFFF;
  localparam logic [27:0] MASK_AN_SPDIF = 28'h0000FFF;
  localparam logic [27:0] MASK_AN8 = 28'h00000FF;
  localparam logic [15:0] DOUBLE_KHZ = 16'h0038;
  localparam logic [15:0] QUAD_KHZ = 16'h0070;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRC_WCK = 3'h0, SRC_OPT1 = 3'h1, SRC_OPT2 = 3'h2,
    SRC_SPDIF = 3'h3, SRC_LTC = 3'h4, SRC_VIDEO = 3'h5
  } src_type;
  typedef enum logic [1:0] {
    LK_NONE = 2'h0, LK_LOCK = 2'h1, LK_SYNC = 2'h2
  } lock_type;
  typedef enum logic [1:0] {
    BW_ALL = 2'h0, BW_NO_OPT2 = 2'h1, BW_AN_SPDIF = 2'h2, BW_AN8 = 2'h3
  } bw_type;
  typedef enum logic [1:0] {
    SPD_SINGLE = 2'h0, SPD_DOUBLE = 2'h1, SPD_QUAD = 2'h2
  } speed_type;
  typedef enum logic {
    CS_MASTER = 1'b0, CS_SLAVE = 1'b1
  } clk_state_type;
endpackage : sync_io_pkg

// ### sim/audio_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module audio_source_model (
  input wire logic core_clk, // system clock
  input wire logic [5:0] lock_en, // sources carrying a signal
  input wire logic [5:0] sync_en, // locked sources also in step
  output logic [5:0] lock_pin, // valid signal per source
  output logic [5:0] sync_pin, // synchronous per source
  output var logic [5:0] ref_clk_pin // recovered word rate per source
);
  // half periods in core cycles: spdif near 44 kHz, the rest near 48 kHz
  localparam int HALF [6] = '{104, 104, 104, 113, 104, 104};
  int cnt [6];
  assign lock_pin = lock_en;
  // sync is only reported with lock
  assign sync_pin = lock_en & sync_en;
  always @(posedge core_clk) begin
    for (int i = 0; i < 6; i++) begin
      if (!lock_en[i]) begin
        cnt[i] = 0;
        // a silent source gives no edges
        ref_clk_pin[i] <= 1'b0;
      end else if (cnt[i] == HALF[i] - 1) begin
        cnt[i] = 0;
        ref_clk_pin[i] <= ~ref_clk_pin[i];
      end else begin
        cnt[i] = cnt[i] + 1;
      end
    end
  end
endmodule : audio_source_model
`default_nettype wire

// ### sim/sync_io_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sync_io_ctrl_tb
  import sync_io_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, cs_data = 8'h00, cs_fwd_data;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [5:0] lock_en = 6'h00, sync_en = 6'h00, lock_pin, sync_pin, ref_clk_pin;
  logic tc_fitted_pin = 1'b0, spdif_coax_rx = 1'b0, opt2_rx = 1'b0, spdif_tx = 1'b0;
  logic opt2_data_tx = 1'b0, host_err = 1'b0, xport_start = 1'b0, cs_valid = 1'b0;
  logic use_internal_clk, wck_out, spdif_rx, spdif_coax_tx, opt2_tx, cs_fwd_valid;
  logic [2:0] ref_sel;
  logic [27:0] in_chan_en, out_chan_en;
  int fail_count = 0, checks_done = 0, cycles = 0;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  sync_io_ctrl i_sync_io_ctrl (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lock_pin(lock_pin), .sync_pin(sync_pin), .ref_clk_pin(ref_clk_pin),
    .tc_fitted_pin(tc_fitted_pin), .use_internal_clk(use_internal_clk), .ref_sel(ref_sel),
    .wck_out(wck_out), .in_chan_en(in_chan_en), .out_chan_en(out_chan_en),
    .spdif_coax_rx(spdif_coax_rx), .opt2_rx(opt2_rx), .spdif_rx(spdif_rx), .spdif_tx(spdif_tx),
    .opt2_data_tx(opt2_data_tx), .spdif_coax_tx(spdif_coax_tx), .opt2_tx(opt2_tx),
    .host_err(host_err), .xport_start(xport_start), .cs_valid(cs_valid), .cs_data(cs_data),
    .cs_fwd_valid(cs_fwd_valid), .cs_fwd_data(cs_fwd_data));
  audio_source_model i_audio_source_model (.core_clk(core_clk), .lock_en(lock_en),
    .sync_en(sync_en), .lock_pin(lock_pin), .sync_pin(sync_pin), .ref_clk_pin(ref_clk_pin));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // bus, compare and wait helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_near(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
    checks_done++;
    if (got + tol >= exp && got <= exp + tol) begin
    end else begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_near
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic wait_sel(input logic intl, input logic [2:0] sel);
    for (int i = 0; i < 20; i++) begin
      if (use_internal_clk === intl && (intl || ref_sel === sel)) break;
      @(posedge core_clk);
    end
    chk({31'h0, use_internal_clk}, {31'h0, intl});
    if (!intl) chk({29'h0, ref_sel}, {29'h0, sel});
  endtask : wait_sel
  task automatic wck_period(output logic [31:0] p);
    int n = 0;
    p = 0;
    while (wck_out !== 1'b0 && n < 2000) begin @(posedge core_clk); n++; end
    while (wck_out !== 1'b1 && n < 4000) begin @(posedge core_clk); n++; end
    while (wck_out === 1'b1 && p < 2000) begin @(posedge core_clk); p++; end
    while (wck_out === 1'b0 && p < 4000) begin @(posedge core_clk); p++; end
  endtask : wck_period
  task automatic pulse(input logic e, input logic s);
    host_err <= e;
    xport_start <= s;
    @(posedge core_clk);
    host_err <= 1'b0;
    xport_start <= 1'b0;
    @(posedge core_clk);
  endtask : pulse
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    #1 chk({31'h0, use_internal_clk}, 32'h1);
    chk({4'h0, in_chan_en & out_chan_en}, 32'h0FFF_FFFF);
    rd(A_INTDIV, d);
    chk(d, 32'h0000_0068);
    wr(8'h20, 32'hFFFF_FFFF);
    wr(A_STATUS, 32'h0000_1FFF);
    rd(8'h20, d);
    chk(d, 32'h0);
    rd(A_STATUS, d);
    chk(d & 32'h0000_0FFF, 32'h0);
    rd(A_CTRL, d);
    chk(d, 32'h0);
  endtask : t_reset
  task automatic t_bandwidth;
    logic [27:0] m [4] = '{28'hFFFFFFF, 28'h00FFFFF, 28'h0000FFF, 28'h00000FF};
    for (int b = 0; b < 4; b++) begin
      wr(A_CTRL, 32'(b) << CTRL_BW_LSB);
      settle();
      chk({4'h0, in_chan_en}, {4'h0, m[b]});
      chk({4'h0, out_chan_en}, {4'h0, m[b]});
    end
  endtask : t_bandwidth
  task automatic t_route;
    wr(A_CTRL, 32'h0);
    spdif_coax_rx <= 1'b1;
    spdif_tx <= 1'b1;
    settle();
    chk({29'h0, spdif_rx, spdif_coax_tx, opt2_tx}, 32'h6);
    wr(A_CTRL, 32'h0000_0180);
    spdif_tx <= 1'b0;
    opt2_data_tx <= 1'b1;
    opt2_rx <= 1'b1;
    spdif_coax_rx <= 1'b0;
    settle();
    chk({29'h0, spdif_rx, spdif_coax_tx, opt2_tx}, 32'h4);
  endtask : t_route
  task automatic t_select;
    logic [5:0] lk [8] = '{6'h00, 6'h02, 6'h02, 6'h0A, 6'h10, 6'h10, 6'h20, 6'h02};
    logic [11:0] cw [8] = '{12'h003, 12'h003, 12'h001, 12'h005, 12'h009, 12'h009, 12'h00B, 12'h002};
    logic tc [8] = '{0, 0, 0, 0, 0, 1, 1, 0};
    logic ex [8] = '{1, 0, 0, 0, 1, 0, 0, 1};
    logic [2:0] es [8] = '{0, 1, 1, 3, 0, 4, 5, 0};
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      lock_en <= lk[i];
      tc_fitted_pin <= tc[i];
      wr(A_CTRL, {20'h0, cw[i]});
      repeat (4) @(posedge core_clk);
      wait_sel(ex[i], es[i]);
    end
    lock_en <= 6'h0F;
    sync_en <= 6'h05;
    tc_fitted_pin <= 1'b0;
    wr(A_CTRL, 32'h1);
    repeat (4) @(posedge core_clk);
    wait_sel(1'b0, 3'h0);
    rd(A_STATUS, d);
    chk(d & 32'h0000_1FFF, 32'h0000_0661);
    repeat (2 * GATE_CYCLES + 20) @(posedge core_clk);
    rd(A_REF_FREQ, d);
    chk_near(d, 32'd48, 32'd1);
    rd(A_SPDIF_FREQ, d);
    chk_near(d, 32'd44, 32'd1);
  endtask : t_select
  task automatic t_wck;
    logic [11:0] cw [3] = '{12'h000, 12'h810, 12'h800};
    logic [15:0] dv [3] = '{16'h0068, 16'h0019, 16'h0019};
    logic [31:0] ep [3] = '{32'd210, 32'd208, 32'd52};
    logic [31:0] p;
    lock_en <= 6'h00;
    for (int i = 0; i < 3; i++) begin
      wr(A_INTDIV, {16'h0, dv[i]});
      wr(A_CTRL, {20'h0, cw[i]});
      wck_period(p);
      wck_period(p);
      chk_near(p, ep[i], 32'd2);
    end
  endtask : t_wck
  task automatic t_errors;
    logic [31:0] d;
    rd(A_ERRORS, d);
    chk(d, 32'h0);
    repeat (3) pulse(1'b1, 1'b0);
    rd(A_ERRORS, d);
    chk(d, 32'h0001_0003);
    pulse(1'b0, 1'b1);
    rd(A_ERRORS, d);
    chk(d, 32'h0);
    pulse(1'b1, 1'b1);
    rd(A_ERRORS, d);
    chk(d, 32'h0001_0001);
  endtask : t_errors
  task automatic t_passthru;
    for (int en = 0; en < 2; en++) begin
      wr(A_CTRL, 32'(en) << CTRL_PASSTHRU);
      cs_data <= 8'hA5 ^ 8'(en);
      cs_valid <= 1'b1;
      @(posedge core_clk);
      cs_valid <= 1'b0;
      #1 chk({23'h0, cs_fwd_valid, cs_fwd_data & {8{en[0]}}}, {23'h0, en[0], 8'hA4 & {8{en[0]}}});
      @(posedge core_clk);
      #1 chk({31'h0, cs_fwd_valid}, 32'h0);
    end
  endtask : t_passthru
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("mismatches=%0d comparisons=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_bandwidth();
    t_route();
    t_select();
    t_wck();
    t_errors();
    t_passthru();
    tally_and_finish();
  end
endmodule : sync_io_ctrl_tb
`default_nettype wire
